//--- hw/prox_sense_map.vh
// register map, field positions and reset values of the proximity channel configuration bank
`ifndef PROX_SENSE_MAP_VH
`define PROX_SENSE_MAP_VH

// register indices; byte address is four times the index
`define IDX_CH3_EMITTER_SELECT 6'h03
`define IDX_PROX_ALIGNMENT 6'h05
`define IDX_AMBIENT_ALIGNMENT 6'h06
`define IDX_CH1_INPUT_SELECT 6'h07
`define IDX_MEASUREMENT_MODE 6'h0C
`define IDX_CHANNEL_STATUS 6'h0D

// reset values
`define RST_CH3_EMITTER_SELECT 8'h04
`define RST_PROX_ALIGNMENT 8'h00
`define RST_AMBIENT_ALIGNMENT 8'h00
`define RST_CH1_INPUT_SELECT 8'h03
`define RST_MEASUREMENT_MODE 8'h04

// writable bits of each register, the rest read zero
`define MASK_CH3_EMITTER_SELECT 8'h07
`define MASK_PROX_ALIGNMENT 8'h70
`define MASK_AMBIENT_ALIGNMENT 8'h30
`define MASK_CH1_INPUT_SELECT 8'hFF
`define MASK_MEASUREMENT_MODE 8'h04

// field positions
`define BIT_CH1_LOW_WORD 4
`define BIT_CH2_LOW_WORD 5
`define BIT_CH3_LOW_WORD 6
`define BIT_AMBIENT_VISIBLE_LOW_WORD 4
`define BIT_AMBIENT_INFRARED_LOW_WORD 5
`define BIT_MEASUREMENT_MODE 2

// channel codes on the conversion port
`define CHAN_PROX1 3'h0
`define CHAN_PROX2 3'h1
`define CHAN_PROX3 3'h2
`define CHAN_AMBIENT_VISIBLE 3'h3
`define CHAN_AMBIENT_INFRARED 3'h4

// input selector codes
`define SEL_SMALL_IR 8'h00
`define SEL_VISIBLE 8'h02
`define SEL_LARGE_IR 8'h03
`define SEL_NO_DIODE 8'h06
`define SEL_GROUND 8'h25
`define SEL_TEMPERATURE 8'h65
`define SEL_SUPPLY 8'h75

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hw/result_aligner.v
// picks the reported 16-bit word out of one 17-bit conversion
`timescale 1ns/1ns
module result_aligner #(
  parameter CONV_WIDTH = 17,
  parameter WORD_WIDTH = 16
) (
  input wire [CONV_WIDTH-1:0] conversion,
  input wire low_word,
  output wire [WORD_WIDTH-1:0] word
);
  // low word drops the top bit, high word drops the bottom bit
  assign word = low_word ? conversion[WORD_WIDTH-1:0] : conversion[CONV_WIDTH-1:CONV_WIDTH-WORD_WIDTH];
endmodule

//--- hw/prox_sense_channel_config.v
// channel configuration register bank with axi4-lite slave, result alignment and emitter steering
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "prox_sense_map.vh"
module prox_sense_channel_config #(
  parameter ADDR_WIDTH = 8,
  parameter CONV_WIDTH = 17,
  parameter WORD_WIDTH = 16,
  parameter NUM_CHANNELS = 5
) (
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire awvalid,
  output wire awready,
  input wire [ADDR_WIDTH-1:0] awaddr,
  input wire [2:0] awprot,
  // axi4-lite write data
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // axi4-lite write response
  output wire bvalid,
  input wire bready,
  output wire [1:0] bresp,
  // axi4-lite read address
  input wire arvalid,
  output wire arready,
  input wire [ADDR_WIDTH-1:0] araddr,
  input wire [2:0] arprot,
  // axi4-lite read data
  output wire rvalid,
  input wire rready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  // conversion results from the converter
  input wire conv_valid,
  input wire [2:0] conv_channel,
  input wire [CONV_WIDTH-1:0] conv_data,
  output wire result_valid,
  output wire [2:0] result_channel,
  output wire [WORD_WIDTH-1:0] result_data,
  // emitter drive during the third proximity measurement
  input wire ch3_measure_active,
  output wire emitter_pin_1,
  output wire emitter_pin_2,
  output wire emitter_pin_3,
  // analog selector for the first proximity channel
  output wire [7:0] prox_ch1_input_select,
  output wire ch1_select_supported
);

  // configuration registers
  reg [7:0] prox_ch3_emitter_select_q; // ch3 emitter mask
  reg [7:0] prox_result_alignment_q; // prox low word selects
  reg [7:0] ambient_result_alignment_q; // ambient low word selects
  reg [7:0] prox_ch1_input_select_q; // ch1 analog input
  reg [7:0] prox_measurement_mode_q; // normal or raw mode

  // bus handshake state
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  // outputs of the datapath
  reg result_valid_q;
  reg [2:0] result_channel_q;
  reg [WORD_WIDTH-1:0] result_data_q;
  reg [2:0] emitter_q;
  reg supported_q;

  wire [5:0] wr_index;
  wire [5:0] rd_index;
  wire wr_fire;
  wire rd_fire;
  wire mode_normal;
  wire [2:0] ch3_emitter_mask;
  wire [NUM_CHANNELS-1:0] low_word_sel; // per channel alignment bit
  wire [WORD_WIDTH*NUM_CHANNELS-1:0] aligned; // every channel's aligned word
  reg sel_ok;
  reg wr_mapped;
  reg [7:0] rd_value;
  reg rd_mapped;

  // byte address to register index; low two bits ignored
  assign wr_index = awaddr[7:2];
  assign rd_index = araddr[7:2];
  assign wr_fire = awready_q & awvalid & wready_q & wvalid;
  assign rd_fire = arready_q & arvalid;

  assign mode_normal = prox_measurement_mode_q[`BIT_MEASUREMENT_MODE];
  assign ch3_emitter_mask = prox_ch3_emitter_select_q[2:0];

  // channel order follows the channel codes
  assign low_word_sel[0] = prox_result_alignment_q[`BIT_CH1_LOW_WORD];
  assign low_word_sel[1] = prox_result_alignment_q[`BIT_CH2_LOW_WORD];
  assign low_word_sel[2] = prox_result_alignment_q[`BIT_CH3_LOW_WORD];
  // bits follow their names; the swapped wording is not taken
  assign low_word_sel[3] = ambient_result_alignment_q[`BIT_AMBIENT_VISIBLE_LOW_WORD];
  assign low_word_sel[4] = ambient_result_alignment_q[`BIT_AMBIENT_INFRARED_LOW_WORD];

  // one aligner per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHANNELS; gi = gi + 1) begin : g_align
      result_aligner #(
        .CONV_WIDTH(CONV_WIDTH),
        .WORD_WIDTH(WORD_WIDTH)
      ) u_align (
        .conversion(conv_data),
        .low_word(low_word_sel[gi]),
        .word(aligned[gi*WORD_WIDTH +: WORD_WIDTH])
      );
    end
  endgenerate

  // selector code check against the current mode
  always @* begin
    case (prox_ch1_input_select_q)
      `SEL_LARGE_IR: sel_ok = 1'b1;
      `SEL_SMALL_IR: sel_ok = 1'b1;
      `SEL_VISIBLE: sel_ok = ~mode_normal;
      `SEL_NO_DIODE: sel_ok = ~mode_normal;
      `SEL_GROUND: sel_ok = ~mode_normal;
      `SEL_TEMPERATURE: sel_ok = ~mode_normal;
      `SEL_SUPPLY: sel_ok = ~mode_normal;
      default: sel_ok = 1'b0; // unsupported code
    endcase
  end

  // write decode
  always @* begin
    case (wr_index)
      `IDX_CH3_EMITTER_SELECT: wr_mapped = 1'b1;
      `IDX_PROX_ALIGNMENT: wr_mapped = 1'b1;
      `IDX_AMBIENT_ALIGNMENT: wr_mapped = 1'b1;
      `IDX_CH1_INPUT_SELECT: wr_mapped = 1'b1;
      `IDX_MEASUREMENT_MODE: wr_mapped = 1'b1;
      `IDX_CHANNEL_STATUS: wr_mapped = 1'b1; // read only, write ignored
      default: wr_mapped = 1'b0;
    endcase
  end

  // read decode; reserved bits are masked off in storage
  always @* begin
    rd_mapped = 1'b1;
    case (rd_index)
      `IDX_CH3_EMITTER_SELECT: rd_value = prox_ch3_emitter_select_q;
      `IDX_PROX_ALIGNMENT: rd_value = prox_result_alignment_q;
      `IDX_AMBIENT_ALIGNMENT: rd_value = ambient_result_alignment_q;
      `IDX_CH1_INPUT_SELECT: rd_value = prox_ch1_input_select_q;
      `IDX_MEASUREMENT_MODE: rd_value = prox_measurement_mode_q;
      `IDX_CHANNEL_STATUS: rd_value = {5'h00, emitter_q[2], emitter_q[1] | emitter_q[0], supported_q};
      default: begin
        rd_value = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // write channel: take address and data together, one write at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      // ready only for one cycle, while both channels are offered
      if (awvalid && wvalid && !awready_q && !bvalid_q) begin
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end else begin
        awready_q <= 1'b0;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // register storage; only byte lane 0 carries data
  always @(posedge aclk) begin
    if (!aresetn) begin
      prox_ch3_emitter_select_q <= `RST_CH3_EMITTER_SELECT;
      prox_result_alignment_q <= `RST_PROX_ALIGNMENT;
      ambient_result_alignment_q <= `RST_AMBIENT_ALIGNMENT;
      prox_ch1_input_select_q <= `RST_CH1_INPUT_SELECT;
      prox_measurement_mode_q <= `RST_MEASUREMENT_MODE;
    end else if (wr_fire && wstrb[0]) begin
      // reserved bits never stored, so they read zero
      case (wr_index)
        `IDX_CH3_EMITTER_SELECT: prox_ch3_emitter_select_q <= wdata[7:0] & `MASK_CH3_EMITTER_SELECT;
        `IDX_PROX_ALIGNMENT: prox_result_alignment_q <= wdata[7:0] & `MASK_PROX_ALIGNMENT;
        `IDX_AMBIENT_ALIGNMENT: ambient_result_alignment_q <= wdata[7:0] & `MASK_AMBIENT_ALIGNMENT;
        `IDX_CH1_INPUT_SELECT: prox_ch1_input_select_q <= wdata[7:0] & `MASK_CH1_INPUT_SELECT;
        `IDX_MEASUREMENT_MODE: prox_measurement_mode_q <= wdata[7:0] & `MASK_MEASUREMENT_MODE;
        default: prox_measurement_mode_q <= prox_measurement_mode_q; // unmapped or read only
      endcase
    end
  end

  // read channel: address taken, data one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `RESP_OKAY;
    end else begin
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h000000, rd_value};
        rresp_q <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // result path: one cycle from conversion to aligned word
  always @(posedge aclk) begin
    if (!aresetn) begin
      result_valid_q <= 1'b0;
      result_channel_q <= 3'h0;
      result_data_q <= {WORD_WIDTH{1'b0}};
    end else begin
      // unknown channel codes are dropped, not reported
      result_valid_q <= conv_valid && (conv_channel < NUM_CHANNELS);
      if (conv_valid && (conv_channel < NUM_CHANNELS)) begin
        result_channel_q <= conv_channel;
        result_data_q <= aligned[conv_channel*WORD_WIDTH +: WORD_WIDTH];
      end
    end
  end

  // emitter drive; the mask is not checked against fitted emitters, software keeps absent ones clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      emitter_q <= 3'h0;
    end else if (ch3_measure_active && mode_normal) begin
      emitter_q <= ch3_emitter_mask; // any combination at once
    end else begin
      emitter_q <= 3'h0; // raw mode forces emitters off
    end
  end

  // selector status, registered for a clean output
  always @(posedge aclk) begin
    if (!aresetn) begin
      supported_q <= 1'b1;
    end else begin
      supported_q <= sel_ok;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign result_valid = result_valid_q;
  assign result_channel = result_channel_q;
  assign result_data = result_data_q;
  assign emitter_pin_1 = emitter_q[0];
  assign emitter_pin_2 = emitter_q[1];
  assign emitter_pin_3 = emitter_q[2];
  assign prox_ch1_input_select = prox_ch1_input_select_q;
  assign ch1_select_supported = supported_q;

endmodule

//--- bench/prox_sense_channel_config_assertions.sv
// port checks for the channel configuration bank
`timescale 1ns/1ns
module prox_sense_channel_config_assertions #(
  parameter CONV_WIDTH = 17,
  parameter WORD_WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire bvalid,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire [31:0] rdata,
  input wire conv_valid,
  input wire [2:0] conv_channel,
  input wire [CONV_WIDTH-1:0] conv_data,
  input wire result_valid,
  input wire [WORD_WIDTH-1:0] result_data,
  input wire ch3_measure_active,
  input wire emitter_pin_1,
  input wire emitter_pin_2,
  input wire emitter_pin_3,
  input wire [7:0] prox_ch1_input_select,
  input wire ch1_select_supported
);
  // one domain, quiet while in reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [7:0] s = prox_ch1_input_select; // short alias
  wire take = conv_valid && (conv_channel < 3'h5); // conversion the bank must take
  // both candidate words of a conversion
  wire [WORD_WIDTH-1:0] lo_w = conv_data[WORD_WIDTH-1:0];
  wire [WORD_WIDTH-1:0] hi_w = conv_data[CONV_WIDTH-1:1];
  // codes legal in any mode, codes legal in none
  wire base = (s == 8'h00) || (s == 8'h03);
  wire odd = !base && (s != 8'h02) && (s != 8'h06) && (s != 8'h25) && (s != 8'h65) && (s != 8'h75);
  wire pins = emitter_pin_1 || emitter_pin_2 || emitter_pin_3; // any emitter on
  chk_result_latency: assert property (take |=> result_valid)
    else $error("result missing");
  chk_bad_channel: assert property (!take |=> !result_valid)
    else $error("stray result");
  chk_result_word: assert property (take |=> result_data == $past(lo_w) || result_data == $past(hi_w))
    else $error("result word neither half");
  chk_pins_idle: assert property (!ch3_measure_active |=> !pins)
    else $error("emitter on outside window");
  chk_write_answer: assert property (awvalid && awready |=> bvalid)
    else $error("late write response");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("late read data");
  chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_sel_base: assert property (base && $stable(s) |=> !$stable(s) || ch1_select_supported)
    else $error("base code refused");
  chk_sel_odd: assert property (odd && $stable(s) |=> !$stable(s) || !ch1_select_supported)
    else $error("odd code accepted");
endmodule
// attach to every instance of the bank
bind prox_sense_channel_config prox_sense_channel_config_assertions #(
  .CONV_WIDTH(CONV_WIDTH),
  .WORD_WIDTH(WORD_WIDTH)
) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
  .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
  .result_valid(result_valid), .result_data(result_data), .ch3_measure_active(ch3_measure_active),
  .emitter_pin_1(emitter_pin_1), .emitter_pin_2(emitter_pin_2), .emitter_pin_3(emitter_pin_3),
  .prox_ch1_input_select(prox_ch1_input_select), .ch1_select_supported(ch1_select_supported)
);

//--- bench/tb_prox_sense_channel_config.sv
// self-checking bench for the channel configuration bank
`timescale 1ns/1ns
`include "prox_sense_map.vh"
module tb_prox_sense_channel_config;
  reg aclk = 1'b0; // 25 MHz clock
  reg aresetn = 1'b0; // held low 16 cycles
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // bus controls
  reg [7:0] awaddr = 8'h00, araddr = 8'h00; // byte addresses
  reg [2:0] awprot = 3'h0, arprot = 3'h0; // ignored by the bank
  reg [31:0] wdata = 32'h0; // upper bits carry noise
  reg [3:0] wstrb = 4'h0; // lanes
  reg conv_valid = 1'b0, ch3_measure_active = 1'b0; // converter side
  reg [2:0] conv_channel = 3'h0; // channel code
  reg [16:0] conv_data = 17'h0; // raw conversion
  wire awready, wready, bvalid, arready, rvalid, result_valid, ch1_select_supported; // design flags
  wire emitter_pin_1, emitter_pin_2, emitter_pin_3; // emitter levels
  wire [1:0] bresp, rresp; // responses
  wire [31:0] rdata; // read word
  wire [2:0] result_channel; // result tag
  wire [15:0] result_data; // result word
  wire [7:0] prox_ch1_input_select; // selector output
  integer seed, miscompares = 0, checks_done = 0, cyc = 0, i, k, c; // bookkeeping
  reg [31:0] d; // read back
  reg [1:0] rs; // response
  reg [7:0] pa, aa, v; // random values
  reg [31:0] rnd; // raw random word, sliced on purpose
  localparam [31:0] RSTV = 32'h04000003; // reset of idx 3,5,6,7
  localparam [31:0] MSKV = 32'h077030FF; // writable bits of idx 3,5,6,7
  localparam [63:0] CODES = 64'h0003020625657511; // selector codes, last one unsupported
  prox_sense_channel_config u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
    .result_valid(result_valid), .result_channel(result_channel), .result_data(result_data),
    .ch3_measure_active(ch3_measure_active),
    .emitter_pin_1(emitter_pin_1), .emitter_pin_2(emitter_pin_2), .emitter_pin_3(emitter_pin_3),
    .prox_ch1_input_select(prox_ch1_input_select), .ch1_select_supported(ch1_select_supported)
  );
  always #20 aclk = ~aclk;
  // table slot to register index
  function [5:0] idx_of(input integer n);
    idx_of = (n == 0) ? 6'h03 : 6'h04 + n[5:0];
  endfunction
  // word the bank should report
  function [15:0] align(input [16:0] x, input lo);
    align = lo ? x[15:0] : x[16:1];
  endfunction
  // raw mode widens the legal set
  function legal(input [7:0] s, input normal);
    legal = s == 8'h00 || s == 8'h03 ||
      (!normal && (s == 8'h02 || s == 8'h06 || s == 8'h25 || s == 8'h65 || s == 8'h75));
  endfunction
  // one comparison, unknowns never match
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // address and data offered together, response awaited
  task wr(input [5:0] idx, input [7:0] val, output [1:0] resp);
    reg [31:0] r;
    reg aw_done, w_done;
    begin
      r = $random(seed);
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awaddr <= {idx, 2'h0};
      wdata <= {r[31:8], val};
      wstrb <= 4'hF;
      // each channel released at its own handshake edge, in either order
      while (!(aw_done && w_done)) begin
        @(posedge aclk);
        if (!aw_done && awready === 1'b1) begin
          awvalid <= 1'b0;
          aw_done = 1'b1;
        end
        if (!w_done && wready === 1'b1) begin
          wvalid <= 1'b0;
          w_done = 1'b1;
        end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
    end
  endtask
  // read one register
  task rd(input [5:0] idx, output [31:0] val, output [1:0] resp);
    begin
      @(posedge aclk);
      arvalid <= 1'b1;
      rready <= 1'b1;
      araddr <= {idx, 2'h0};
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      val = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask
  // verdict and end of run
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // hang guard, the run needs under 1000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  initial begin
    seed = 32'h7C80D5BE;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values
    for (i = 0; i < 4; i = i + 1) begin
      rd(idx_of(i), d, rs);
      chk(d, RSTV[31-8*i -: 8]);
    end
    // mode defaults to normal, status shows a legal selector and no emitter
    rd(`IDX_MEASUREMENT_MODE, d, rs);
    chk(d, {24'h000000, `RST_MEASUREMENT_MODE});
    rd(`IDX_CHANNEL_STATUS, d, rs);
    chk(d, 32'h00000001);
    // status is read only: write answered okay, nothing changes
    wr(`IDX_CHANNEL_STATUS, 8'hFF, rs);
    chk(rs, `RESP_OKAY);
    rd(`IDX_CHANNEL_STATUS, d, rs);
    chk(d, 32'h00000001);
    // random fill, reserved bits read zero
    for (k = 0; k < 24; k = k + 1) begin
      i = {$random(seed)} % 4;
      rnd = $random(seed);
      // alignment registers get their low nibble clear
      v = (i == 1 || i == 2) ? {rnd[7:4], 4'h0} : rnd[7:0];
      wr(idx_of(i), v, rs);
      chk(rs, `RESP_OKAY);
      rd(idx_of(i), d, rs);
      chk(d, v & MSKV[31-8*i -: 8]);
      chk(rs, `RESP_OKAY);
    end
    // unmapped places answer with an error
    rd(6'h01, d, rs);
    chk(rs, `RESP_SLVERR);
    chk(d, 32'h00000000);
    wr(6'h3F, 8'hFF, rs);
    chk(rs, `RESP_SLVERR);
    // alignment per channel, code 5 dropped
    for (k = 0; k < 4; k = k + 1) begin
      rnd = $random(seed);
      pa = (k < 2) ? {1'b0, {3{k[0]}}, 4'h0} : {rnd[7:4], 4'h0};
      aa = (k < 2) ? {2'h0, {2{k[0]}}, 4'h0} : {rnd[15:12], 4'h0};
      wr(`IDX_PROX_ALIGNMENT, pa, rs);
      wr(`IDX_AMBIENT_ALIGNMENT, aa, rs);
      for (c = 0; c < 6; c = c + 1) begin
        @(posedge aclk);
        conv_valid <= 1'b1;
        conv_channel <= c[2:0];
        rnd = $random(seed);
        conv_data <= rnd[16:0];
        @(posedge aclk);
        conv_valid <= 1'b0;
        @(negedge aclk);
        chk(result_valid, c < 5);
        if (c < 5) chk({result_channel, result_data}, {c[2:0], align(conv_data, c < 3 ? pa[4+c] : aa[c+1])});
      end
    end
    // every mask in both modes
    for (k = 0; k < 16; k = k + 1) begin
      v = k[3] ? 8'h00 : {5'h00, k[2:0]};
      wr(`IDX_CH3_EMITTER_SELECT, {5'h00, k[2:0]}, rs); // a three-emitter part, every enable fitted
      wr(`IDX_MEASUREMENT_MODE, {5'h00, !k[3], 2'h0}, rs);
      @(posedge aclk);
      ch3_measure_active <= 1'b1;
      @(posedge aclk);
      @(negedge aclk);
      chk({emitter_pin_3, emitter_pin_2, emitter_pin_1}, v[2:0]);
      // status shows pin 3 and pins 1 or 2 ored into one bit while the window stays open
      rd(`IDX_CHANNEL_STATUS, d, rs);
      chk(d[7:1], {4'h0, v[2], v[1] | v[0]});
      ch3_measure_active <= 1'b0;
      repeat (2) @(negedge aclk);
      chk({emitter_pin_3, emitter_pin_2, emitter_pin_1}, 3'h0);
    end
    // each selector code in both modes
    for (k = 0; k < 16; k = k + 1) begin
      v = CODES[63-8*(k%8) -: 8];
      wr(`IDX_CH1_INPUT_SELECT, v, rs);
      wr(`IDX_MEASUREMENT_MODE, {5'h0, k < 8, 2'h0}, rs);
      repeat (3) @(negedge aclk);
      chk({ch1_select_supported, prox_ch1_input_select}, {legal(v, k < 8), v});
    end
    conclude;
  end
endmodule
